//--- rtl/reread_guard.sv
// Repeat-read suppression timer with millisecond divider
`timescale 1ns/1ps
module reread_guard #(
   parameter int MS_CYCLES = scanner_cfg_pkg::CYC_PER_MS,
   parameter int ID_W      = 16
) (
   // Clock and reset
   input  wire logic                             i_sys_clk,
   input  wire logic                             i_rst,
   // Configuration
   input  wire logic                             i_cont_mode,
   input  wire logic [scanner_cfg_pkg::RRD_W-1:0] i_delay_shared,
   input  wire logic [scanner_cfg_pkg::RRD_W-1:0] i_delay_two,
   // Candidate and accepted reads
   input  wire logic [ID_W-1:0]                  i_id,
   input  wire logic                             i_is_2d,
   input  wire logic                             i_accept,
   output logic                                  o_block
);

   localparam int DIV_W = $clog2(MS_CYCLES + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

   typedef struct packed {
      logic [DIV_W-1:0]                     div;
      logic [scanner_cfg_pkg::RRD_W-1:0]    cnt;
      logic [ID_W-1:0]                      last;
   } guard_s;

   guard_s q;
   guard_s d;
   logic [scanner_cfg_pkg::RRD_W-1:0] delay;

   // ************************************************************
   // Delay select and countdown
   // ************************************************************
   always_comb begin
      d = q;
      delay = (i_is_2d && i_delay_two != '0) ? i_delay_two : i_delay_shared;
      if (i_accept && i_cont_mode) begin
         d.cnt  = delay;
         d.last = i_id;
         d.div  = '0;
      end else if (q.cnt != '0) begin
         if (q.div == DIV_LAST) begin
            d.div = '0;
            d.cnt = q.cnt - 1'b1;
         end else begin
            d.div = q.div + 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_block = i_cont_mode && (q.cnt != '0) && (q.last == i_id);

endmodule

//--- rtl/scanner_cfg_pkg.sv
// Shared constants and types for the scanner decode configuration block
package scanner_cfg_pkg;

   // ************************************************************
   // Register word addresses
   // ************************************************************
   localparam logic [15:0] ADDR_RRD_SHARED = 16'h0B49;
   localparam logic [15:0] ADDR_RRD_TWO    = 16'h0B4A;
   localparam logic [15:0] ADDR_WIN_EN     = 16'h113D;
   localparam logic [15:0] ADDR_WIN_LEFT   = 16'h113E;
   localparam logic [15:0] ADDR_WIN_RIGHT  = 16'h113F;
   localparam logic [15:0] ADDR_WIN_TOP    = 16'h1140;
   localparam logic [15:0] ADDR_WIN_BOTTOM = 16'h1141;
   localparam logic [15:0] ADDR_LIN_ASSIST = 16'h1146;
   localparam logic [15:0] ADDR_STK_ASSIST = 16'h1247;
   localparam logic [15:0] ADDR_ILLUM      = 16'h132C;
   localparam logic [15:0] ADDR_INVERT     = 16'h1855;
   localparam logic [15:0] ADDR_LEAD_STR   = 16'h1B58;
   localparam logic [15:0] ADDR_TRAIL_STR  = 16'h1C58;

   // ************************************************************
   // Field widths, limits and reset values
   // ************************************************************
   localparam int          RRD_W   = 15;
   localparam int          WIN_W   = 7;
   localparam int          CHAR_W  = 7;
   localparam int          STR_LEN = 10;
   localparam int          IDX_W   = 4;
   localparam logic [14:0] RRD_MAX        = 15'h7530;
   localparam logic [14:0] RST_RRD_SHARED = 15'h02EE;
   localparam logic [14:0] RST_RRD_TWO    = 15'h0000;
   localparam logic [6:0]  WIN_MAX        = 7'h64;
   localparam logic [6:0]  RST_WIN_LO     = 7'h28;
   localparam logic [6:0]  RST_WIN_HI     = 7'h3C;
   localparam logic        RST_ILLUM      = 1'b1;
   localparam logic [6:0]  CHAR_MIN       = 7'h20;
   localparam logic [6:0]  CHAR_BSL       = 7'h5C;
   localparam logic [6:0]  CHAR_NONE      = 7'h00;

   // ************************************************************
   // Inverted code modes
   // ************************************************************
   localparam logic [1:0] INV_NORMAL = 2'h0;
   localparam logic [1:0] INV_ONLY   = 2'h1;
   localparam logic [1:0] INV_BOTH   = 2'h2;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS         = 1000000;
   localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic [STR_LEN-1:0][CHAR_W-1:0] ch;
      logic [IDX_W-1:0]               len;
      logic [IDX_W-1:0]               nxt;
      logic                           esc;
   } str_s;

endpackage

//--- rtl/scanner_decode_config_regs.sv
// Decode and output configuration registers of the fixed scanner
`timescale 1ns/1ps
module scanner_decode_config_regs #(
   parameter int MS_CYCLES = scanner_cfg_pkg::CYC_PER_MS,
   parameter int ID_W      = 16
) (
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   // Register port
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   input  wire logic [15:0]       i_reg_addr,
   input  wire logic [15:0]       i_reg_wdata,
   output logic                   o_reg_ack,
   output logic                   o_reg_err,
   output logic [15:0]            o_reg_rdata,
   // Trigger mode and exposure
   input  wire logic              i_cont_mode,
   input  wire logic              i_exposing,
   // Decoder candidate
   input  wire logic              i_dec_valid,
   input  wire logic [ID_W-1:0]   i_dec_id,
   input  wire logic              i_dec_is_2d,
   input  wire logic              i_dec_inverted,
   input  wire logic [6:0]        i_dec_left,
   input  wire logic [6:0]        i_dec_right,
   input  wire logic [6:0]        i_dec_top,
   input  wire logic [6:0]        i_dec_bottom,
   output logic                   o_dec_ready,
   output logic                   o_dec_accept,
   output logic                   o_dec_reject,
   // Decoded data in
   input  wire logic              i_data_valid,
   input  wire logic [7:0]        i_data_char,
   input  wire logic              i_data_last,
   output logic                   o_data_ready,
   // Character stream out
   output logic                   o_tx_valid,
   output logic [7:0]             o_tx_char,
   input  wire logic              i_tx_ready,
   // Decoder settings
   output logic                   o_linear_assist,
   output logic                   o_stacked_assist,
   output logic [1:0]             o_invert_mode,
   output logic                   o_illum_drive
);

   localparam int RW = scanner_cfg_pkg::RRD_W;
   localparam int WW = scanner_cfg_pkg::WIN_W;
   localparam int IW = scanner_cfg_pkg::IDX_W;
   localparam int CW = scanner_cfg_pkg::CHAR_W;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD,
      ST_DATA,
      ST_TRAIL,
      ST_DROP
   } seq_e;

   typedef struct packed {
      logic [RW-1:0]         rrd_shared;
      logic [RW-1:0]         rrd_two;
      logic                  win_en;
      logic [WW-1:0]         win_left;
      logic [WW-1:0]         win_right;
      logic [WW-1:0]         win_top;
      logic [WW-1:0]         win_bottom;
      logic                  lin;
      logic                  stk;
      logic                  illum;
      logic [1:0]            inv;
      scanner_cfg_pkg::str_s lead;
      scanner_cfg_pkg::str_s trail;
      logic                  ack;
      logic                  err;
      logic [15:0]           rdata;
      seq_e                  st;
      logic [IW-1:0]         idx;
      logic                  tx_v;
      logic [7:0]            tx_c;
      logic                  acc;
      logic                  rej;
      logic                  lamp;
   } regs_s;

   regs_s q;
   regs_s d;

   // ************************************************************
   // Helper functions
   // ************************************************************
   function automatic logic [IW-1:0] str_off(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] diff;
      diff = a - base;
      return diff[IW-1:0];
   endfunction

   function automatic logic str_hit(input logic [15:0] a, input logic [15:0] base);
      return (a >= base) && (a < base + 16'(scanner_cfg_pkg::STR_LEN));
   endfunction

   // legal only from start or next in sequence
   function automatic logic str_ok(input scanner_cfg_pkg::str_s s,
                                   input logic [IW-1:0] off, input logic [CW-1:0] c);
      logic room;
      room = (s.len < IW'(scanner_cfg_pkg::STR_LEN)) ||
             (c == scanner_cfg_pkg::CHAR_BSL && s.esc);
      if (off == '0) begin
         return (c == scanner_cfg_pkg::CHAR_NONE) || (c >= scanner_cfg_pkg::CHAR_MIN);
      end
      return (off == s.nxt) && (s.nxt != '0) && (c >= scanner_cfg_pkg::CHAR_MIN) && room;
   endfunction

   function automatic scanner_cfg_pkg::str_s str_put(input scanner_cfg_pkg::str_s s,
                                                     input logic [IW-1:0] off,
                                                     input logic [CW-1:0] c);
      scanner_cfg_pkg::str_s r;
      r = s;
      if (off == '0) begin
         r = '0;
         if (c == scanner_cfg_pkg::CHAR_NONE) begin
            return r;
         end
      end
      r.nxt = off + 1'b1;
      if (c == scanner_cfg_pkg::CHAR_BSL && s.esc && off != '0) begin
         r.esc = 1'b0;
      end else begin
         r.ch[r.len] = c;
         r.len       = r.len + 1'b1;
         r.esc       = (c == scanner_cfg_pkg::CHAR_BSL);
      end
      return r;
   endfunction

   function automatic logic [15:0] str_rd(input scanner_cfg_pkg::str_s s,
                                          input logic [IW-1:0] off);
      if (off < s.len) begin
         return {9'h000, s.ch[off]};
      end
      return 16'h0000;
   endfunction

   // ************************************************************
   // Candidate filtering
   // ************************************************************
   logic guard_block;
   logic win_ok;
   logic inv_ok;
   logic pass;
   logic tx_free;
   logic [IW-1:0] lead_off;
   logic [IW-1:0] trail_off;

   assign win_ok = i_cont_mode || !q.win_en ||
                   ((i_dec_left <= q.win_right) && (i_dec_right >= q.win_left) &&
                    (i_dec_top <= q.win_bottom) && (i_dec_bottom >= q.win_top));

   always_comb begin
      case (q.inv)
         scanner_cfg_pkg::INV_NORMAL: inv_ok = !i_dec_inverted;
         scanner_cfg_pkg::INV_ONLY:   inv_ok = i_dec_inverted;
         scanner_cfg_pkg::INV_BOTH:   inv_ok = 1'b1;
         default:                     inv_ok = !i_dec_inverted;
      endcase
   end

   // refuse repeats still inside the delay
   assign pass      = win_ok && inv_ok && !guard_block;
   assign tx_free   = !q.tx_v || i_tx_ready;
   assign lead_off  = str_off(i_reg_addr, scanner_cfg_pkg::ADDR_LEAD_STR);
   assign trail_off = str_off(i_reg_addr, scanner_cfg_pkg::ADDR_TRAIL_STR);

   reread_guard #(
      .MS_CYCLES (MS_CYCLES),
      .ID_W      (ID_W)
   ) u_guard (
      .i_sys_clk      (i_sys_clk),
      .i_rst          (i_rst),
      .i_cont_mode    (i_cont_mode),
      .i_delay_shared (q.rrd_shared),
      .i_delay_two    (q.rrd_two),
      .i_id           (i_dec_id),
      .i_is_2d        (i_dec_is_2d),
      .i_accept       (d.acc),
      .o_block        (guard_block)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d       = q;
      d.ack   = i_reg_wr || i_reg_rd;
      d.err   = 1'b0;
      d.acc   = 1'b0;
      d.rej   = 1'b0;
      // lamp follows exposure only when enabled
      d.lamp  = q.illum && i_exposing;

      // Register writes; out of range values are refused with err
      if (i_reg_wr) begin
         case (i_reg_addr)
            scanner_cfg_pkg::ADDR_RRD_SHARED: begin
               if (i_reg_wdata[RW-1:0] <= scanner_cfg_pkg::RRD_MAX && !i_reg_wdata[15]) begin
                  d.rrd_shared = i_reg_wdata[RW-1:0];
               end else begin
                  d.err = 1'b1;
               end
            end
            scanner_cfg_pkg::ADDR_RRD_TWO: begin
               if (i_reg_wdata[RW-1:0] <= scanner_cfg_pkg::RRD_MAX && !i_reg_wdata[15]) begin
                  d.rrd_two = i_reg_wdata[RW-1:0];
               end else begin
                  d.err = 1'b1;
               end
            end
            scanner_cfg_pkg::ADDR_WIN_EN:     d.win_en = i_reg_wdata[0];
            scanner_cfg_pkg::ADDR_WIN_LEFT,
            scanner_cfg_pkg::ADDR_WIN_RIGHT,
            scanner_cfg_pkg::ADDR_WIN_TOP,
            scanner_cfg_pkg::ADDR_WIN_BOTTOM: begin
               if (i_reg_wdata <= {9'h000, scanner_cfg_pkg::WIN_MAX}) begin
                  case (i_reg_addr)
                     scanner_cfg_pkg::ADDR_WIN_LEFT:  d.win_left  = i_reg_wdata[WW-1:0];
                     scanner_cfg_pkg::ADDR_WIN_RIGHT: d.win_right = i_reg_wdata[WW-1:0];
                     scanner_cfg_pkg::ADDR_WIN_TOP:   d.win_top   = i_reg_wdata[WW-1:0];
                     default:                         d.win_bottom = i_reg_wdata[WW-1:0];
                  endcase
               end else begin
                  d.err = 1'b1;
               end
            end
            scanner_cfg_pkg::ADDR_LIN_ASSIST: d.lin   = i_reg_wdata[0];
            scanner_cfg_pkg::ADDR_STK_ASSIST: d.stk   = i_reg_wdata[0];
            scanner_cfg_pkg::ADDR_ILLUM:      d.illum = i_reg_wdata[0];
            scanner_cfg_pkg::ADDR_INVERT: begin
               // code 3 is not a mode
               if (i_reg_wdata[1:0] != 2'h3 && i_reg_wdata[15:2] == '0) begin
                  d.inv = i_reg_wdata[1:0];
               end else begin
                  d.err = 1'b1;
               end
            end
            default: begin
               if (str_hit(i_reg_addr, scanner_cfg_pkg::ADDR_LEAD_STR) &&
                   i_reg_wdata[15:CW] == '0 &&
                   str_ok(q.lead, lead_off, i_reg_wdata[CW-1:0])) begin
                  d.lead = str_put(q.lead, lead_off, i_reg_wdata[CW-1:0]);
               end else if (str_hit(i_reg_addr, scanner_cfg_pkg::ADDR_TRAIL_STR) &&
                            i_reg_wdata[15:CW] == '0 &&
                            str_ok(q.trail, trail_off, i_reg_wdata[CW-1:0])) begin
                  d.trail = str_put(q.trail, trail_off, i_reg_wdata[CW-1:0]);
               end else begin
                  d.err = 1'b1;
               end
            end
         endcase
      end

      // Register reads
      if (i_reg_rd) begin
         d.rdata = 16'h0000;
         case (i_reg_addr)
            scanner_cfg_pkg::ADDR_RRD_SHARED: d.rdata = {1'b0, q.rrd_shared};
            scanner_cfg_pkg::ADDR_RRD_TWO:    d.rdata = {1'b0, q.rrd_two};
            scanner_cfg_pkg::ADDR_WIN_EN:     d.rdata = {15'h0000, q.win_en};
            scanner_cfg_pkg::ADDR_WIN_LEFT:   d.rdata = {9'h000, q.win_left};
            scanner_cfg_pkg::ADDR_WIN_RIGHT:  d.rdata = {9'h000, q.win_right};
            scanner_cfg_pkg::ADDR_WIN_TOP:    d.rdata = {9'h000, q.win_top};
            scanner_cfg_pkg::ADDR_WIN_BOTTOM: d.rdata = {9'h000, q.win_bottom};
            scanner_cfg_pkg::ADDR_LIN_ASSIST: d.rdata = {15'h0000, q.lin};
            scanner_cfg_pkg::ADDR_STK_ASSIST: d.rdata = {15'h0000, q.stk};
            scanner_cfg_pkg::ADDR_ILLUM:      d.rdata = {15'h0000, q.illum};
            scanner_cfg_pkg::ADDR_INVERT:     d.rdata = {14'h0000, q.inv};
            default: begin
               if (str_hit(i_reg_addr, scanner_cfg_pkg::ADDR_LEAD_STR)) begin
                  d.rdata = str_rd(q.lead, lead_off);
               end else if (str_hit(i_reg_addr, scanner_cfg_pkg::ADDR_TRAIL_STR)) begin
                  d.rdata = str_rd(q.trail, trail_off);
               end else begin
                  d.err = 1'b1;
               end
            end
         endcase
      end

      // Output sequencer; output stage empties as the sink takes a char
      if (tx_free) begin
         d.tx_v = 1'b0;
      end
      case (q.st)
         ST_IDLE: begin
            if (i_dec_valid) begin
               d.idx = '0;
               if (pass) begin
                  d.acc = 1'b1;
                  d.st  = ST_LEAD;
               end else begin
                  // rejected code's decoded data is drained to its last char and none of it is sent
                  d.rej = 1'b1;
                  d.st  = ST_DROP;
               end
            end
         end
         ST_LEAD: begin
            if (q.idx == q.lead.len) begin
               d.st = ST_DATA;
            end else if (tx_free) begin
               d.tx_v = 1'b1;
               d.tx_c = {1'b0, q.lead.ch[q.idx]};
               d.idx  = q.idx + 1'b1;
            end
         end
         ST_DATA: begin
            if (tx_free && i_data_valid) begin
               d.tx_v = 1'b1;
               d.tx_c = i_data_char;
               if (i_data_last) begin
                  d.idx = '0;
                  d.st  = ST_TRAIL;
               end
            end
         end
         ST_TRAIL: begin
            if (q.idx == q.trail.len) begin
               d.st = ST_IDLE;
            end else if (tx_free) begin
               d.tx_v = 1'b1;
               d.tx_c = {1'b0, q.trail.ch[q.idx]};
               d.idx  = q.idx + 1'b1;
            end
         end
         ST_DROP: begin
            if (i_data_valid && i_data_last) begin
               d.st = ST_IDLE;
            end
         end
         default: d.st = ST_IDLE;
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         q            <= '0;
         q.rrd_shared <= scanner_cfg_pkg::RST_RRD_SHARED;
         q.rrd_two    <= scanner_cfg_pkg::RST_RRD_TWO;
         q.win_left   <= scanner_cfg_pkg::RST_WIN_LO;
         q.win_right  <= scanner_cfg_pkg::RST_WIN_HI;
         q.win_top    <= scanner_cfg_pkg::RST_WIN_LO;
         q.win_bottom <= scanner_cfg_pkg::RST_WIN_HI;
         q.illum      <= scanner_cfg_pkg::RST_ILLUM;
         q.st         <= ST_IDLE;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_reg_ack        = q.ack;
   assign o_reg_err        = q.err;
   assign o_reg_rdata      = q.rdata;
   assign o_dec_ready      = (q.st == ST_IDLE);
   assign o_dec_accept     = q.acc;
   assign o_dec_reject     = q.rej;
   assign o_data_ready     = (q.st == ST_DROP) || ((q.st == ST_DATA) && tx_free);
   assign o_tx_valid       = q.tx_v;
   assign o_tx_char        = q.tx_c;
   assign o_linear_assist  = q.lin;
   assign o_stacked_assist = q.stk;
   // mode reaches the decoder and also sets which candidates pass here; no image path is touched
   assign o_invert_mode    = q.inv;
   assign o_illum_drive    = q.lamp;

endmodule

//--- test/host_sink_model.sv
// Character stream consumer standing in for the serial host
`timescale 1ns/1ps
module host_sink_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_char,
   output logic            o_tx_ready = 1'b0
);
   logic [7:0] got[$];
   // Stalls every other cycle so the sender must hold each character
   // Moves on the rising edge so ready stays put while the bench looks at data_ready
   always @(posedge i_sys_clk or posedge i_rst) o_tx_ready <= i_rst ? 1'b0 : ~o_tx_ready;
   always @(posedge i_sys_clk) if (i_tx_valid && o_tx_ready) got.push_back(i_tx_char);
endmodule

//--- test/scanner_decode_config_regs_checker.sv
// Concurrent checks on the ports of the scanner configuration block
`timescale 1ns/1ps
module scanner_decode_config_regs_checker (
   input wire logic       i_sys_clk, i_rst, i_reg_wr, i_reg_rd, o_reg_ack, o_reg_err,
   input wire logic       i_dec_valid, o_dec_ready, o_dec_accept, o_dec_reject,
   input wire logic       o_tx_valid, i_tx_ready, i_exposing, o_illum_drive,
   input wire logic [7:0] o_tx_char,
   input wire logic [1:0] o_invert_mode
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   sequence s_req; i_reg_wr || i_reg_rd; endsequence
   sequence s_take; o_dec_ready && i_dec_valid; endsequence
   sequence s_quiet; !o_tx_valid [*2]; endsequence
   reg_ack_a: assert property (s_req |=> o_reg_ack) else $error("ack missing");
   ack_cause_a: assert property (o_reg_ack |-> $past(i_reg_wr || i_reg_rd))
      else $error("ack without request");
   err_ack_a: assert property (o_reg_err |-> o_reg_ack) else $error("lone err");
   dec_answer_a: assert property (s_take |=> o_dec_accept != o_dec_reject)
      else $error("no single verdict");
   accept_busy_a: assert property (o_dec_accept |-> !o_dec_ready)
      else $error("ready during accept");
   reject_quiet_a: assert property (o_dec_reject |=> s_quiet)
      else $error("output after reject");
   tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_char))
      else $error("char dropped while stalled");
   illum_gate_a: assert property (o_illum_drive |-> $past(i_exposing))
      else $error("light outside reading");
   invert_legal_a: assert property (o_invert_mode != 2'h3) else $error("bad mode");
endmodule

bind scanner_decode_config_regs scanner_decode_config_regs_checker CHK (.i_sys_clk, .i_rst,
   .i_reg_wr, .i_reg_rd, .o_reg_ack, .o_reg_err, .i_dec_valid, .o_dec_ready, .o_dec_accept,
   .o_dec_reject, .o_tx_valid, .i_tx_ready, .i_exposing, .o_illum_drive, .o_tx_char,
   .o_invert_mode);

//--- test/scanner_decode_config_regs_tb_top.sv
// Self-checking testbench for the scanner configuration block
`timescale 1ns/1ps
module scanner_decode_config_regs_tb_top;
   logic        i_sys_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic        i_cont_mode = 1'b0, i_exposing = 1'b1, i_dec_valid = 1'b0, i_data_valid = 1'b0;
   logic        two_d = 1'b0, inv_in = 1'b0;
   logic        o_reg_ack, o_reg_err, o_dec_ready, o_dec_accept, o_dec_reject, o_data_ready;
   logic        o_tx_valid, i_tx_ready, o_linear_assist, o_stacked_assist, o_illum_drive;
   logic [15:0] i_reg_addr = 16'h0, i_reg_wdata = 16'h0, i_dec_id = 16'h0, o_reg_rdata;
   logic [6:0]  lo = 7'h0, hi = 7'h0;
   logic [7:0]  o_tx_char;
   logic [1:0]  o_invert_mode;
   int          err_total = 0, tests_run = 0, cyc = 0;
   // Address in the upper half, reset value in the lower half
   localparam logic [31:0] RST_TAB [13] = '{32'h0B4902EE, 32'h0B4A0000, 32'h113D0000,
      32'h113E0028, 32'h113F003C, 32'h11400028, 32'h1141003C, 32'h11460000, 32'h12470000,
      32'h132C0001, 32'h18550000, 32'h1B580000, 32'h1C580000};
   always #20 i_sys_clk = ~i_sys_clk;
   scanner_decode_config_regs #(.MS_CYCLES(4)) DUT (.*, .i_dec_is_2d(two_d),
      .i_dec_inverted(inv_in), .i_dec_left(lo), .i_dec_right(hi), .i_dec_top(lo),
      .i_dec_bottom(hi), .i_data_char(8'h78), .i_data_last(1'b1));
   host_sink_model PEER (.i_sys_clk, .i_rst, .i_tx_valid(o_tx_valid), .i_tx_char(o_tx_char),
      .o_tx_ready(i_tx_ready));
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         test_done();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [15:0] a, d, input logic e);
      @(negedge i_sys_clk);
      {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {w, !w, a, d};
      @(negedge i_sys_clk);
      {i_reg_wr, i_reg_rd} = 2'b00;
      chk(w ? {14'h0000, o_reg_ack, o_reg_err} : o_reg_rdata, w ? {14'h0000, 1'b1, e} : d);
   endtask
   task automatic wr(input logic [15:0] a, d, input logic e); bus(1'b1, a, d, e); endtask
   task automatic rd(input logic [15:0] a, d); bus(1'b0, a, d, 1'b0); endtask
   // Offers one code, checks the verdict, then hands over its one data character
   task automatic code(input logic [15:0] i, input logic [6:0] l, h, input logic a);
      @(negedge i_sys_clk);
      {i_dec_valid, i_dec_id, lo, hi} = {1'b1, i, l, h};
      while (!o_dec_ready) @(negedge i_sys_clk);
      @(negedge i_sys_clk);
      i_dec_valid = 1'b0;
      chk(16'({o_dec_accept, o_dec_reject}), 16'({a, !a}));
      i_data_valid = 1'b1;
      while (!o_data_ready) @(negedge i_sys_clk);
      @(negedge i_sys_clk);
      i_data_valid = 1'b0;
      repeat (8) @(negedge i_sys_clk);
   endtask
   initial begin
      repeat (4) @(negedge i_sys_clk);
      i_rst = 1'b0;
      foreach (RST_TAB[k]) rd(RST_TAB[k][31:16], RST_TAB[k][15:0]);
      chk(16'({o_linear_assist, o_stacked_assist, o_invert_mode, o_illum_drive}), 16'h1);
      $display("reset values done");
      wr(16'h0B49, 16'h7530, 1'b0);
      wr(16'h0B49, 16'h7531, 1'b1);
      rd(16'h0B49, 16'h7530);
      wr(16'h0B4A, 16'h8000, 1'b1);
      wr(16'h113E, 16'h0065, 1'b1);
      wr(16'h1855, 16'h0003, 1'b1);
      wr(16'h2000, 16'h0001, 1'b1);
      for (int m = 0; m < 3; m++) begin
         wr(16'h1855, 16'(m), 1'b0);
         @(negedge i_sys_clk);
         chk(16'(o_invert_mode), 16'(m));
      end
      wr(16'h1146, 16'h0001, 1'b0);
      wr(16'h1247, 16'h0001, 1'b0);
      wr(16'h132C, 16'h0000, 1'b0);
      @(negedge i_sys_clk);
      chk(16'({o_linear_assist, o_stacked_assist, o_invert_mode, o_illum_drive}), 16'h1C);
      wr(16'h132C, 16'h0001, 1'b0);
      i_exposing = 1'b0;
      @(negedge i_sys_clk);
      chk(16'(o_illum_drive), 16'h0000);
      i_exposing = 1'b1;
      $display("field checks done");
      wr(16'h1C58, 16'h0010, 1'b1);
      wr(16'h1C58, 16'h0021, 1'b0);
      wr(16'h1C59, 16'h005C, 1'b0);
      wr(16'h1C5A, 16'h005C, 1'b0);
      rd(16'h1C59, 16'h005C);
      rd(16'h1C5A, 16'h0000);
      wr(16'h1C5C, 16'h0041, 1'b1);
      wr(16'h1C58, 16'h0000, 1'b0);
      rd(16'h1C58, 16'h0000);
      for (int k = 0; k < 10; k++) wr(16'h1B58 + 16'(k), 16'h0041, 1'b0);
      wr(16'h1B62, 16'h0041, 1'b1);
      wr(16'h1B58, 16'h0041, 1'b0);
      rd(16'h1B59, 16'h0000);
      $display("string checks done");
      code(16'h0001, 7'h28, 7'h32, 1'b1);
      chk({PEER.got[0], PEER.got[1]}, 16'h4178);
      wr(16'h113E, 16'h001E, 1'b0);
      wr(16'h1141, 16'h0046, 1'b0);
      wr(16'h113D, 16'h0001, 1'b0);
      code(16'h0002, 7'h00, 7'h0A, 1'b0);
      code(16'h0003, 7'h1E, 7'h28, 1'b1);
      wr(16'h1855, 16'h0001, 1'b0);
      code(16'h0009, 7'h28, 7'h32, 1'b0);
      inv_in = 1'b1;
      wr(16'h1B58, 16'h0000, 1'b0);
      code(16'h0004, 7'h28, 7'h32, 1'b1);
      chk(16'(PEER.got.size()), 16'h0005);
      $display("output checks done");
      i_cont_mode = 1'b1;
      two_d = 1'b1;
      wr(16'h0B49, 16'h0014, 1'b0);
      code(16'h0005, 7'h28, 7'h32, 1'b1);
      code(16'h0005, 7'h28, 7'h32, 1'b0);
      code(16'h0006, 7'h28, 7'h32, 1'b1);
      repeat (100) @(negedge i_sys_clk);
      code(16'h0006, 7'h28, 7'h32, 1'b1);
      i_cont_mode = 1'b0;
      code(16'h0006, 7'h28, 7'h32, 1'b1);
      i_cont_mode = 1'b1;
      wr(16'h0B49, 16'h0000, 1'b0);
      code(16'h0007, 7'h28, 7'h32, 1'b1);
      code(16'h0007, 7'h28, 7'h32, 1'b1);
      wr(16'h0B4A, 16'h0014, 1'b0);
      code(16'h0008, 7'h28, 7'h32, 1'b1);
      code(16'h0008, 7'h28, 7'h32, 1'b0);
      $display("reread checks done");
      test_done();
   end
endmodule
